// ### rtl/epm_pin_mux.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module epm_pin_mux (
   input  wire logic                   I_CLK_SYS,
   input  wire logic                   I_RST,
   input  wire logic                   I_PROCESSOR_MODE_PIN,
   input  wire logic                   I_BUS_WIDTH_SEL,
   output logic                        O_BUS_ENABLE_N,
   input  wire logic [7:0]             I_LOW_ADDRESS_PORT_IN,
   output logic      [7:0]             O_LOW_ADDRESS_PORT_OUT,
   output logic      [7:0]             O_LOW_ADDRESS_PORT_OE,
   input  wire logic [7:0]             I_MIDDLE_ADDRESS_DATA_PORT_IN,
   output logic      [7:0]             O_MIDDLE_ADDRESS_DATA_PORT_OUT,
   output logic      [7:0]             O_MIDDLE_ADDRESS_DATA_PORT_OE,
   input  wire logic [7:0]             I_HIGH_ADDRESS_DATA_PORT_IN,
   output logic      [7:0]             O_HIGH_ADDRESS_DATA_PORT_OUT,
   output logic      [7:0]             O_HIGH_ADDRESS_DATA_PORT_OE,
   input  wire logic [3:0]             I_BUS_CONTROL_PORT_IN,
   output logic      [3:0]             O_BUS_CONTROL_PORT_OUT,
   output logic      [3:0]             O_BUS_CONTROL_PORT_OE,
   input  wire logic [7:0]             I_BUS_HANDSHAKE_PORT_IN,
   output logic      [7:0]             O_BUS_HANDSHAKE_PORT_OUT,
   output logic      [7:0]             O_BUS_HANDSHAKE_PORT_OE,
   input  wire logic [7:0]             I_ANALOG_INPUT_PORT_IN,
   output logic      [7:0]             O_ANALOG_INPUT_PORT_OUT,
   output logic      [7:0]             O_ANALOG_INPUT_PORT_OE,
   output logic      [7:0]             O_ANALOG_CHANNELS,
   output logic                        O_ADC_TRIGGER,
   input  wire logic                   I_REQ_VALID,
   input  wire epm_pkg::epm_req_type   I_REQ,
   output logic                        O_REQ_READY,
   output logic                        O_RSP_VALID,
   output logic      [15:0]            O_RSP_RDATA,
   input  wire logic                   I_AWVALID,
   output logic                        O_AWREADY,
   input  wire logic [epm_pkg::AXI_AW-1:0] I_AWADDR,
   input  wire logic                   I_WVALID,
   output logic                        O_WREADY,
   input  wire logic [31:0]            I_WDATA,
   input  wire logic [3:0]             I_WSTRB,
   output logic                        O_BVALID,
   input  wire logic                   I_BREADY,
   output logic      [1:0]             O_BRESP,
   input  wire logic                   I_ARVALID,
   output logic                        O_ARREADY,
   input  wire logic [epm_pkg::AXI_AW-1:0] I_ARADDR,
   output logic                        O_RVALID,
   input  wire logic                   I_RREADY,
   output logic      [31:0]            O_RDATA,
   output logic      [1:0]             O_RRESP
);
   import epm_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0]          pin_in   [NUM_PORTS];
   logic [7:0]          pin_out  [NUM_PORTS];
   logic [7:0]          pin_oe   [NUM_PORTS];
   logic [7:0]          func_en  [NUM_PORTS];
   logic [7:0]          func_out [NUM_PORTS];
   logic [7:0]          func_oe  [NUM_PORTS];
   logic [7:0]          rd_data  [8];
   logic [7:0]          rd_dir   [8];
   logic [NUM_PORTS-1:0] data_we;
   logic [NUM_PORTS-1:0] dir_we;

   logic                mode_q;
   logic [1:0]          ctrl_q;
   logic                clk_div_q;
   epm_state_type       state_q;
   epm_req_type         req_q;
   logic                rsp_valid_q;
   logic [15:0]         rsp_rdata_q;

   logic                aw_full_q;
   logic [AXI_AW-1:0]   aw_addr_q;
   logic                w_full_q;
   logic [7:0]          w_data_q;
   logic                w_strb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic epm_hit(input logic [AXI_AW-1:0] a);
      epm_hit = (a[7:6] == 2'h0) && (a[1:0] == 2'h0) &&
                (a[5:3] != SPARE_IDX);
   endfunction

   // ----------------------------------------------------------------
   // Mode selection
   // ----------------------------------------------------------------
   // Pin level is caught while reset is applied
   // mode pin sets processor mode
   // reset length is the outside party's duty
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         mode_q <= I_PROCESSOR_MODE_PIN;
      end
   end

   wire micro_mode = mode_q;
   wire expansion  = mode_q | ctrl_q[CTRL_EXP_BIT];
   wire wide_bus   = ~I_BUS_WIDTH_SEL;
   // hold and ready taken from handshake port
   wire hold_req   = expansion & pin_in[HSHK_SLOT][HOLD_BIT];
   wire bus_ready  = pin_in[HSHK_SLOT][RDY_BIT];
   wire clkout_en  = micro_mode | ctrl_q[CTRL_CLK_BIT];

   // ----------------------------------------------------------------
   // Clock output divider
   // ----------------------------------------------------------------
   // oscillator divided by two
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         clk_div_q <= 1'b0;
      end else begin
         clk_div_q <= ~clk_div_q;
      end
   end

   // ----------------------------------------------------------------
   // External bus cycle sequencer
   // ----------------------------------------------------------------
   // Hold is granted only between cycles, never mid-transfer
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         state_q     <= ST_IDLE;
         req_q       <= '0;
         rsp_valid_q <= 1'b0;
         rsp_rdata_q <= 16'h0000;
      end else begin
         rsp_valid_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (hold_req) begin
                  state_q <= ST_HOLD;
               end else if (I_REQ_VALID && expansion) begin
                  req_q   <= I_REQ;
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               state_q <= ST_DATA;
            end
            ST_DATA: begin
               if (bus_ready) begin
                  rsp_valid_q <= 1'b1;
                  rsp_rdata_q <= {wide_bus ? pin_in[MID_ADDR_SLOT] : 8'h00,
                                  pin_in[HIGH_ADDR_SLOT]};
                  state_q     <= ST_IDLE;
               end
            end
            ST_HOLD: begin
               if (!hold_req) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Bus strobes decoded from the state register
   wire in_data  = (state_q == ST_DATA);
   wire in_addr  = (state_q == ST_ADDR);
   wire in_hold  = (state_q == ST_HOLD);
   wire drive_ok = ~in_hold;
   // enable low only in the data phase
   assign O_BUS_ENABLE_N = ~in_data;
   assign O_REQ_READY    = (state_q == ST_IDLE) & expansion & ~hold_req;
   assign O_RSP_VALID    = rsp_valid_q;
   assign O_RSP_RDATA    = rsp_rdata_q;

   // ----------------------------------------------------------------
   // Pin function overrides
   // ----------------------------------------------------------------
   // low address byte
   assign func_en[LOW_ADDR_SLOT]  = {8{expansion}};
   assign func_out[LOW_ADDR_SLOT] = req_q.addr[7:0];
   assign func_oe[LOW_ADDR_SLOT]  = {8{drive_ok}};

   assign func_en[MID_ADDR_SLOT]  = {8{expansion}};
   assign func_out[MID_ADDR_SLOT] = (in_data && wide_bus) ?
                                    req_q.wdata[15:8] : req_q.addr[15:8];
   assign func_oe[MID_ADDR_SLOT]  = {8{drive_ok & (~in_data | ~wide_bus |
                                                   req_q.write)}};

   // low data or top address byte
   assign func_en[HIGH_ADDR_SLOT]  = {8{expansion}};
   assign func_out[HIGH_ADDR_SLOT] = in_data ? req_q.wdata[7:0] :
                                               req_q.addr[23:16];
   assign func_oe[HIGH_ADDR_SLOT]  = {8{drive_ok & (~in_data | req_q.write)}};

   // strobe, byte enable, latch enable, grant
   // Strobes float during hold; the grant itself keeps driving
   assign func_en[CTRL_SLOT]  = {4'h0, {CTRL_PORT_W{expansion}}};
   assign func_out[CTRL_SLOT] = {4'h0, in_hold, in_addr,
                                 ~req_q.upper, ~req_q.write};
   assign func_oe[CTRL_SLOT]  = {4'h0, 1'b1, {3{drive_ok}}};

   // hold and ready pins forced to input in expansion mode
   assign func_en[HSHK_SLOT]  = {5'h00, clkout_en, expansion, expansion};
   assign func_out[HSHK_SLOT] = {5'h00, clk_div_q, 2'h0};
   assign func_oe[HSHK_SLOT]  = {5'h00, 1'b1, 2'h0};

   // Analog port has no bus function
   assign func_en[ANALOG_SLOT]  = 8'h00;
   assign func_out[ANALOG_SLOT] = 8'h00;
   assign func_oe[ANALOG_SLOT]  = 8'h00;

   assign O_ANALOG_CHANNELS = pin_in[ANALOG_SLOT];
   assign O_ADC_TRIGGER     = pin_in[ANALOG_SLOT][TRIG_BIT];

   // ----------------------------------------------------------------
   // Pin wiring
   // ----------------------------------------------------------------
   assign pin_in[LOW_ADDR_SLOT]  = I_LOW_ADDRESS_PORT_IN;
   assign pin_in[MID_ADDR_SLOT]  = I_MIDDLE_ADDRESS_DATA_PORT_IN;
   assign pin_in[HIGH_ADDR_SLOT] = I_HIGH_ADDRESS_DATA_PORT_IN;
   assign pin_in[CTRL_SLOT]      = {4'h0, I_BUS_CONTROL_PORT_IN};
   assign pin_in[HSHK_SLOT]      = I_BUS_HANDSHAKE_PORT_IN;
   assign pin_in[ANALOG_SLOT]    = I_ANALOG_INPUT_PORT_IN;

   assign O_LOW_ADDRESS_PORT_OUT         = pin_out[LOW_ADDR_SLOT];
   assign O_LOW_ADDRESS_PORT_OE          = pin_oe[LOW_ADDR_SLOT];
   assign O_MIDDLE_ADDRESS_DATA_PORT_OUT = pin_out[MID_ADDR_SLOT];
   assign O_MIDDLE_ADDRESS_DATA_PORT_OE  = pin_oe[MID_ADDR_SLOT];
   assign O_HIGH_ADDRESS_DATA_PORT_OUT   = pin_out[HIGH_ADDR_SLOT];
   assign O_HIGH_ADDRESS_DATA_PORT_OE    = pin_oe[HIGH_ADDR_SLOT];
   assign O_BUS_CONTROL_PORT_OUT         = pin_out[CTRL_SLOT][3:0];
   assign O_BUS_CONTROL_PORT_OE          = pin_oe[CTRL_SLOT][3:0];
   assign O_BUS_HANDSHAKE_PORT_OUT       = pin_out[HSHK_SLOT];
   assign O_BUS_HANDSHAKE_PORT_OE        = pin_oe[HSHK_SLOT];
   assign O_ANALOG_INPUT_PORT_OUT        = pin_out[ANALOG_SLOT];
   assign O_ANALOG_INPUT_PORT_OE         = pin_oe[ANALOG_SLOT];

   // ----------------------------------------------------------------
   // Port banks
   // ----------------------------------------------------------------
   wire       wr_hit  = epm_hit(aw_addr_q);
   wire       do_wr   = aw_full_q & w_full_q & ~bvalid_q;
   wire       wr_go   = do_wr & wr_hit & w_strb_q;
   wire [2:0] wr_idx  = aw_addr_q[5:3];
   wire       wr_isdir = aw_addr_q[2];

   generate
      for (genvar k = 0; k < NUM_PORTS; k++) begin : g_bank
         wire [7:0] mask = PORT_MASK[k*8 +: 8];
         assign data_we[k] = wr_go & (wr_idx == k[2:0]) & ~wr_isdir;
         assign dir_we[k]  = wr_go & (wr_idx == k[2:0]) & wr_isdir;
         epm_port_bank #(.W(PORT_W)) u_bank (
            .i_clk      (I_CLK_SYS),
            .i_rst      (I_RST),
            .i_data_we  (data_we[k]),
            .i_dir_we   (dir_we[k]),
            .i_wdata    (w_data_q & mask),
            .i_func_en  (func_en[k]),
            .i_func_out (func_out[k]),
            .i_func_oe  (func_oe[k]),
            .i_pin_in   (pin_in[k]),
            .o_pin_out  (pin_out[k]),
            .o_pin_oe   (pin_oe[k]),
            .o_rd_data  (rd_data[k]),
            .o_rd_dir   (rd_dir[k])
         );
      end
   endgenerate

   // Slot 6 holds control and status, slot 7 is unmapped
   assign rd_data[CTRL_IDX]  = {6'h00, ctrl_q};
   assign rd_dir[CTRL_IDX]   = {3'h0, in_data | in_addr, in_hold,
                                ~wide_bus, micro_mode, expansion};
   assign rd_data[SPARE_IDX] = 8'h00;
   assign rd_dir[SPARE_IDX]  = 8'h00;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Expansion bit is meaningless in microprocessor mode
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_go && wr_idx == CTRL_IDX && !wr_isdir) begin
         ctrl_q <= w_data_q[1:0];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data are parked separately, so either may come first
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q  <= 1'b0;
         w_data_q  <= 8'h00;
         w_strb_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (I_AWVALID && O_AWREADY) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= I_AWADDR;
         end
         if (I_WVALID && O_WREADY) begin
            w_full_q <= 1'b1;
            w_data_q <= I_WDATA[7:0];
            w_strb_q <= I_WSTRB[0];
         end
         if (do_wr) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && I_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign O_AWREADY = ~aw_full_q & ~bvalid_q;
   assign O_WREADY  = ~w_full_q & ~bvalid_q;
   assign O_BVALID  = bvalid_q;
   assign O_BRESP   = bresp_q;

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   wire       rd_hit  = epm_hit(I_ARADDR);
   wire [2:0] rd_idx  = I_ARADDR[5:3];
   wire [7:0] rd_byte = I_ARADDR[2] ? rd_dir[rd_idx] : rd_data[rd_idx];

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (I_ARVALID && O_ARREADY) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h00_0000, rd_hit ? rd_byte : 8'h00};
         rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && I_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   assign O_ARREADY = ~rvalid_q;
   assign O_RVALID  = rvalid_q;
   assign O_RDATA   = rdata_q;
   assign O_RRESP   = rresp_q;

endmodule // epm_pin_mux

`default_nettype wire

// ### rtl/epm_pkg.sv
package epm_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam int            AXI_AW       = 8;
   localparam int            NUM_PORTS    = 6;
   localparam int            PORT_W       = 8;
   localparam logic [2:0]    CTRL_IDX     = 3'h6;
   localparam logic [2:0]    SPARE_IDX    = 3'h7;
   localparam logic [1:0]    RESP_OKAY    = 2'h0;
   localparam logic [1:0]    RESP_SLVERR  = 2'h2;

   // Port slots in the bank array
   localparam int            LOW_ADDR_SLOT  = 0;
   localparam int            MID_ADDR_SLOT  = 1;
   localparam int            HIGH_ADDR_SLOT = 2;
   localparam int            CTRL_SLOT      = 3;
   localparam int            HSHK_SLOT      = 4;
   localparam int            ANALOG_SLOT    = 5;
   localparam int            CTRL_PORT_W    = 4;

   // Implemented bits of each port, slot 0 in the low byte
   localparam logic [47:0]   PORT_MASK = 48'hFFFF_0FFF_FFFF;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0]    DATA_RESET   = 8'h00;
   localparam logic [7:0]    DIR_RESET    = 8'h00;
   localparam logic [1:0]    CTRL_RESET   = 2'h0;
   localparam int            CTRL_EXP_BIT = 0;
   localparam int            CTRL_CLK_BIT = 1;
   localparam int            ST_EXP_BIT   = 0;
   localparam int            ST_MICRO_BIT = 1;
   localparam int            ST_BYTE_BIT  = 2;
   localparam int            ST_HOLD_BIT  = 3;
   localparam int            ST_BUSY_BIT  = 4;

   // Control, handshake and analog port bit positions
   localparam int            RW_BIT       = 0;
   localparam int            BHE_BIT      = 1;
   localparam int            ALE_BIT      = 2;
   localparam int            HOLD_GRANT_OUTPUT_BIT     = 3;
   localparam int            HOLD_BIT     = 0;
   localparam int            RDY_BIT      = 1;
   localparam int            CLKOUT_BIT   = 2;
   localparam int            TRIG_BIT     = 7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ADDR = 2'h1,
      ST_DATA = 2'h3,
      ST_HOLD = 2'h2
   } epm_state_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        write;
      logic        upper;
   } epm_req_type;

endpackage

// ### rtl/epm_port_bank.sv
`timescale 1ns/1ns
`default_nettype none

module epm_port_bank #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_data_we,
   input  wire logic         i_dir_we,
   input  wire logic [W-1:0] i_wdata,
   input  wire logic [W-1:0] i_func_en,
   input  wire logic [W-1:0] i_func_out,
   input  wire logic [W-1:0] i_func_oe,
   input  wire logic [W-1:0] i_pin_in,
   output logic      [W-1:0] o_pin_out,
   output logic      [W-1:0] o_pin_oe,
   output logic      [W-1:0] o_rd_data,
   output logic      [W-1:0] o_rd_dir
);
   import epm_pkg::*;

   logic [W-1:0] data_q;
   logic [W-1:0] dir_q;

   // ----------------------------------------------------------------
   // Latch and direction registers
   // ----------------------------------------------------------------
   // input after reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         data_q <= DATA_RESET[W-1:0];
         dir_q  <= DIR_RESET[W-1:0];
      end else begin
         if (i_data_we) begin
            data_q <= i_wdata;
         end
         if (i_dir_we) begin
            dir_q <= i_wdata;
         end
      end
   end

   // Outputs read back the latch, inputs read the pin
   assign o_rd_data = (dir_q & data_q) | (~dir_q & i_pin_in);
   assign o_rd_dir  = dir_q;

   // per-bit direction
   // Bus functions take the pin over bit by bit
   assign o_pin_out = (i_func_en & i_func_out) | (~i_func_en & data_q);
   assign o_pin_oe  = (i_func_en & i_func_oe) | (~i_func_en & dir_q);

endmodule // epm_port_bank

`default_nettype wire

// ### verification/epm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module epm_monitor
   import epm_pkg::*;
(
   input wire logic        I_CLK_SYS,
   input wire logic        I_RST,
   input wire logic        I_BUS_WIDTH_SEL,
   input wire logic        O_BUS_ENABLE_N,
   input wire logic [7:0]  O_LOW_ADDRESS_PORT_OUT,
   input wire logic [7:0]  O_MIDDLE_ADDRESS_DATA_PORT_OUT,
   input wire logic [7:0]  O_MIDDLE_ADDRESS_DATA_PORT_OE,
   input wire logic [7:0]  O_HIGH_ADDRESS_DATA_PORT_OUT,
   input wire logic [3:0]  O_BUS_CONTROL_PORT_OUT,
   input wire logic [7:0]  I_BUS_HANDSHAKE_PORT_IN,
   input wire logic        I_REQ_VALID,
   input wire epm_req_type I_REQ,
   input wire logic        O_REQ_READY,
   input wire logic        O_RSP_VALID
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   // Request taken by the sequencer
   wire logic tk = I_REQ_VALID && O_REQ_READY;
   addr_low_a: assert property (tk |=> O_LOW_ADDRESS_PORT_OUT ==
      $past(I_REQ.addr[7:0])) else $error("low address wrong");
   addr_mid_a: assert property (tk |=> O_MIDDLE_ADDRESS_DATA_PORT_OUT ==
      $past(I_REQ.addr[15:8])) else $error("middle address wrong");
   addr_high_a: assert property (tk |=> O_HIGH_ADDRESS_DATA_PORT_OUT ==
      $past(I_REQ.addr[23:16])) else $error("high address wrong");
   narrow_mid_a: assert property (I_BUS_WIDTH_SEL && !O_BUS_ENABLE_N
      |-> O_MIDDLE_ADDRESS_DATA_PORT_OE == 8'hFF) else $error("narrow data");
   enable_phase_a: assert property (tk |=> O_BUS_ENABLE_N
      ##1 !O_BUS_ENABLE_N) else $error("enable phase wrong");
   ale_pulse_a: assert property (tk |=> O_BUS_CONTROL_PORT_OUT[ALE_BIT]
      ##1 !O_BUS_CONTROL_PORT_OUT[ALE_BIT]) else $error("latch pulse wrong");
   strobe_pins_a: assert property (tk |=> O_BUS_CONTROL_PORT_OUT[1:0] ==
      ~{$past(I_REQ.upper), $past(I_REQ.write)}) else $error("strobes wrong");
   ready_end_a: assert property (!O_BUS_ENABLE_N &&
      I_BUS_HANDSHAKE_PORT_IN[RDY_BIT] |=> O_RSP_VALID && O_BUS_ENABLE_N)
      else $error("cycle end wrong");
   // Main scenarios reached
   cover property (tk && I_REQ.write);
   cover property (tk && !I_REQ.write && I_BUS_WIDTH_SEL);
   cover property (!O_BUS_ENABLE_N && !I_BUS_HANDSHAKE_PORT_IN[RDY_BIT]);
endmodule // epm_monitor
bind epm_pin_mux epm_monitor epm_monitor_i (.*);
`default_nettype wire

// ### verification/epm_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
module epm_ext_mem (
   input  wire logic        i_clk,
   input  wire logic        i_enable_n,
   input  wire logic        i_read,
   input  wire logic [2:0]  i_waits,
   input  wire logic [15:0] i_wdata,
   output logic      [15:0] o_rdata,
   output logic             o_ready
);
   logic [15:0] mem_q = 16'h0000;
   logic [2:0]  cnt_q = 3'h0;
   // ready only in a data phase, after the wait count
   assign o_ready = !i_enable_n && cnt_q == i_waits;
   // data only while enabled; a released bus toggles so stale data
   // can never pass for an answer
   always @(posedge i_clk) begin
      cnt_q   <= i_enable_n ? 3'h0 : cnt_q + 3'h1;
      o_rdata <= (!i_enable_n && i_read) ? mem_q : ~o_rdata;
      if (o_ready && !i_read) mem_q <= i_wdata;
   end
endmodule // epm_ext_mem
`default_nettype wire

// ### verification/epm_pin_mux_test.sv
`timescale 1ns/1ns
`default_nettype none
module epm_pin_mux_test;
   import epm_pkg::*;
   logic        I_CLK_SYS = 1'b0, I_RST = 1'b1, I_PROCESSOR_MODE_PIN = 1'b0;
   logic        I_BUS_WIDTH_SEL = 1'b0, I_REQ_VALID = 1'b0, I_AWVALID = 1'b0;
   logic        I_WVALID = 1'b0, I_BREADY = 1'b0, I_ARVALID = 1'b0;
   logic        I_RREADY = 1'b0, hold_q = 1'b0, h, O_BUS_ENABLE_N, O_AWREADY;
   logic        O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_REQ_READY;
   logic        O_RSP_VALID, O_ADC_TRIGGER, mem_rdy;
   logic [7:0]  I_ANALOG_INPUT_PORT_IN = 8'h81, I_AWADDR = '0, I_ARADDR = '0;
   logic [7:0]  I_LOW_ADDRESS_PORT_IN, O_LOW_ADDRESS_PORT_OUT;
   logic [7:0]  O_LOW_ADDRESS_PORT_OE, O_MIDDLE_ADDRESS_DATA_PORT_OUT;
   logic [7:0]  I_MIDDLE_ADDRESS_DATA_PORT_IN, O_MIDDLE_ADDRESS_DATA_PORT_OE;
   logic [7:0]  I_HIGH_ADDRESS_DATA_PORT_IN, O_HIGH_ADDRESS_DATA_PORT_OUT;
   logic [7:0]  O_HIGH_ADDRESS_DATA_PORT_OE, I_BUS_HANDSHAKE_PORT_IN;
   logic [7:0]  O_BUS_HANDSHAKE_PORT_OUT, O_BUS_HANDSHAKE_PORT_OE;
   logic [7:0]  O_ANALOG_INPUT_PORT_OUT, O_ANALOG_INPUT_PORT_OE;
   logic [7:0]  O_ANALOG_CHANNELS;
   logic [3:0]  I_BUS_CONTROL_PORT_IN, O_BUS_CONTROL_PORT_OUT;
   logic [3:0]  O_BUS_CONTROL_PORT_OE, I_WSTRB = 4'hF;
   logic [31:0] I_WDATA = '0, O_RDATA, d;
   logic [15:0] O_RSP_RDATA, mem_rd, rd16;
   logic [1:0]  O_BRESP, O_RRESP, r;
   logic [2:0]  waits = 3'h1;
   epm_req_type I_REQ = '0;
   int          error_cnt = 0, check_count = 0;
   // Released data pins show the far side; pins it drives read back
   assign I_LOW_ADDRESS_PORT_IN = 8'h00;
   assign I_BUS_CONTROL_PORT_IN = 4'h0;
   assign I_MIDDLE_ADDRESS_DATA_PORT_IN = O_MIDDLE_ADDRESS_DATA_PORT_OE[0] ?
      O_MIDDLE_ADDRESS_DATA_PORT_OUT : mem_rd[15:8];
   assign I_HIGH_ADDRESS_DATA_PORT_IN = O_HIGH_ADDRESS_DATA_PORT_OE[0] ?
      O_HIGH_ADDRESS_DATA_PORT_OUT : mem_rd[7:0];
   // hold request on bit 0, ready on bit 1
   assign I_BUS_HANDSHAKE_PORT_IN = {6'h00, mem_rdy, hold_q};
   always #25 I_CLK_SYS = ~I_CLK_SYS;
   epm_pin_mux epm_pin_mux_i (.*);
   epm_ext_mem epm_ext_mem_i (.i_clk(I_CLK_SYS), .i_enable_n(O_BUS_ENABLE_N),
      .i_read(O_BUS_CONTROL_PORT_OUT[RW_BIT]), .i_waits(waits),
      .i_wdata({O_MIDDLE_ADDRESS_DATA_PORT_OUT, O_HIGH_ADDRESS_DATA_PORT_OUT}),
      .o_rdata(mem_rd), .o_ready(mem_rdy));
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // One register access; each channel released at its own handshake
   task automatic axi(input logic wr, logic [7:0] a, logic [31:0] v);
      logic aw, w, ar, done = 1'b0;
      @(posedge I_CLK_SYS);
      {I_AWADDR, I_ARADDR, I_WDATA} <= {a, a, v};
      {I_AWVALID, I_WVALID, I_BREADY} <= {3{wr}};
      {I_ARVALID, I_RREADY} <= {2{!wr}};
      while (!done) begin
         @(negedge I_CLK_SYS);
         {aw, w, ar} = {O_AWREADY, O_WREADY, O_ARREADY};
         done = wr ? O_BVALID : O_RVALID;
         {d, r} = wr ? {32'h0, O_BRESP} : {O_RDATA, O_RRESP};
         @(posedge I_CLK_SYS);
         if (aw) I_AWVALID <= 1'b0;
         if (w) I_WVALID <= 1'b0;
         if (ar) I_ARVALID <= 1'b0;
      end
      {I_BREADY, I_RREADY} <= 2'b00;
   endtask
   // One external bus cycle, pins checked in address and data phase
   task automatic bus(input logic [23:0] a, logic [15:0] v, logic wr);
      @(posedge I_CLK_SYS);
      I_REQ <= '{a, v, wr, 1'b1};
      I_REQ_VALID <= 1'b1;
      do @(negedge I_CLK_SYS); while (!O_REQ_READY);
      @(posedge I_CLK_SYS);
      I_REQ_VALID <= 1'b0;
      @(negedge I_CLK_SYS);
      chk("addr low", a[7:0], O_LOW_ADDRESS_PORT_OUT);
      chk("addr high", a[23:16], O_HIGH_ADDRESS_DATA_PORT_OUT);
      @(negedge I_CLK_SYS);
      chk("enable", 1'b0, O_BUS_ENABLE_N);
      if (wr) chk("data low", v[7:0], O_HIGH_ADDRESS_DATA_PORT_OUT);
      if (wr) chk("data up", I_BUS_WIDTH_SEL ? a[15:8] : v[15:8],
         O_MIDDLE_ADDRESS_DATA_PORT_OUT);
      do @(negedge I_CLK_SYS); while (!O_RSP_VALID);
      rd16 = O_RSP_RDATA;
      @(posedge I_CLK_SYS);
   endtask
   task automatic do_reset(input logic mode);
      @(posedge I_CLK_SYS);
      I_RST <= 1'b1;
      I_PROCESSOR_MODE_PIN <= mode;
      repeat (10) @(posedge I_CLK_SYS);
      I_RST <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #(4000 * 50);
      error_cnt++;
      end_of_test;
   end
   // Main sequence
   initial begin
      do_reset(1'b0);
      axi(1'b0, 8'h04, 32'h0);
      chk("dir reset", 32'h0, d);
      axi(1'b0, 8'h34, 32'h0);
      chk("status", 32'h0, d);
      axi(1'b1, 8'h40, 32'h0);
      chk("bad write", RESP_SLVERR, r);
      axi(1'b1, 8'h04, 32'hFF);
      axi(1'b1, 8'h00, 32'hA5);
      @(negedge I_CLK_SYS);
      chk("pin out", 8'hA5, O_LOW_ADDRESS_PORT_OUT);
      chk("pin oe", 8'hFF, O_LOW_ADDRESS_PORT_OE);
      chk("channels", 8'h81, O_ANALOG_CHANNELS);
      chk("trigger", 1'b1, O_ADC_TRIGGER);
      $display("test single_chip done");
      axi(1'b1, 8'h30, 32'h3);
      chk("clock oe", 1'b1, O_BUS_HANDSHAKE_PORT_OE[CLKOUT_BIT]);
      bus(24'h5A3C07, 16'hBEEF, 1'b1);
      waits <= 3'h4;
      bus(24'h5A3C07, 16'h0000, 1'b0);
      chk("read wide", 16'hBEEF, rd16);
      I_BUS_WIDTH_SEL <= 1'b1;
      bus(24'h123402, 16'h0042, 1'b1);
      bus(24'h123402, 16'h0000, 1'b0);
      chk("read narrow", 16'h0042, rd16);
      hold_q <= 1'b1;
      repeat (3) @(negedge I_CLK_SYS);
      chk("grant", 1'b1, O_BUS_CONTROL_PORT_OUT[HOLD_GRANT_OUTPUT_BIT]);
      chk("req ready", 1'b0, O_REQ_READY);
      @(posedge I_CLK_SYS);
      {hold_q, I_BUS_WIDTH_SEL} <= 2'b00;
      $display("test expansion done");
      do_reset(1'b1);
      axi(1'b0, 8'h34, 32'h0);
      chk("micro", 32'h3, d);
      @(negedge I_CLK_SYS);
      h = O_BUS_HANDSHAKE_PORT_OUT[CLKOUT_BIT];
      @(negedge I_CLK_SYS);
      chk("clock", !h, O_BUS_HANDSHAKE_PORT_OUT[CLKOUT_BIT]);
      bus(24'h123402, 16'h0000, 1'b0);
      chk("read micro", 16'h3442, rd16);
      $display("test microprocessor done");
      end_of_test;
   end
endmodule // epm_pin_mux_test
`default_nettype wire
